// ### core/swsd_pkg.sv
// Package for the synchronous burst RAM write/select decode block
package swsd_pkg;

  // Number of byte lanes
  localparam int unsigned LANES    = 4;
  // Width of one byte lane
  localparam int unsigned LANE_W   = 8;
  // Reset value of the registered lane write mask
  localparam logic [3:0]  MASK_RST = 4'h0;

  // Pipeline state of the output stage
  typedef enum logic [1:0]
  {
    SWSD_IDLE  = 2'b00,
    SWSD_WRITE = 2'b01,
    SWSD_READ  = 2'b10,
    SWSD_SLEEP = 2'b11
  } swsd_state_t;

  // Control inputs sampled on each clock edge
  typedef struct packed
  {
    logic       global_write_n;
    logic       byte_write_gate_n;
    logic [3:0] lane_write_n;
    logic       combined_select_n;
    logic       select_b_high;
    logic       select_c_n;
  } swsd_ctrl_t;

endpackage : swsd_pkg

// ### core/swsd_decode.sv
// Write, select, read and sleep decode of the burst RAM
`timescale 1ns/1ps
`default_nettype none

module swsd_decode
  import swsd_pkg::*;
#(
  parameter int unsigned NUM_LANES = LANES,
  parameter int unsigned LANE_BITS = LANE_W
)
(
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rstn,
  // Control pins from the memory controller
  input  wire logic                          global_write_n,
  input  wire logic                          byte_write_gate_n,
  input  wire logic [NUM_LANES-1:0]          lane_write_n,
  input  wire logic                          combined_select_n,
  input  wire logic                          select_b_high,
  input  wire logic                          select_c_n,
  input  wire logic                          sleep_request,
  // Write data and read data from the core array
  input  wire logic [NUM_LANES*LANE_BITS-1:0] write_data,
  input  wire logic [NUM_LANES*LANE_BITS-1:0] array_read_data,
  // Decoded controls toward the core array
  output logic                               cycle_write,
  output logic                               cycle_read,
  output logic [NUM_LANES-1:0]               lane_write_mask,
  output logic [NUM_LANES*LANE_BITS-1:0]     lane_write_data,
  // Data pins
  output logic [NUM_LANES*LANE_BITS-1:0]     data_out,
  output logic                               data_out_en,
  // Status
  output logic                               selected,
  output logic                               asleep
);

  // Gated lane mask: one bit per lane that is to be written
  function automatic logic [NUM_LANES-1:0] lane_mask
  (
    input logic                 gw_n,
    input logic                 gate_n,
    input logic [NUM_LANES-1:0] lanes_n
  );
    // Global write overrides every lane input
    if (!gw_n)
      lane_mask = '1;
    // Gate low lets each lane input act on its own lane
    else if (!gate_n)
      lane_mask = ~lanes_n;
    // Gate high ignores the lane inputs entirely
    else
      lane_mask = '0;
  endfunction : lane_mask

  // Limitation: burst address sequencing, the output enable pin and the
  // pin drivers live elsewhere; this block only decodes the controls.
  // Sleep is sampled like any other control, so the caller must hold it
  // across a rising edge for it to take effect.

  swsd_state_t state;        // Output stage state
  swsd_state_t next_state;   // Next output stage state

  // Combinational decode, all named wires
  wire logic [NUM_LANES-1:0] mask_now;   // Lanes written this cycle
  wire logic                 write_now;  // This cycle is a write
  wire logic                 sel_now;    // All three enables agree
  wire logic                 active_now; // Selected and not asleep
  wire logic                 read_now;   // This cycle is a read
  wire logic                 desel_now;  // Any one enable is off
  wire logic                 show_read;  // A read was registered last edge

  // Global write forces all lanes; else gate qualifies each lane alone
  assign mask_now   = lane_mask(global_write_n, byte_write_gate_n,
                                lane_write_n);
  // A write needs at least one lane; all enables high stays a read
  assign write_now  = |mask_now;
  // Both low enables low and the high enable high
  assign sel_now    = !combined_select_n && !select_c_n && select_b_high;
  // Sleep gates every access; an open input reads as low upstream
  assign active_now = sel_now && !sleep_request;
  // A read is simply the absence of any lane to write
  assign read_now   = !write_now;
  // One low enable high, or the high enable low, deselects
  assign desel_now  = !sel_now;
  // The output stage drives the pins only for a registered read
  assign show_read  = (state == SWSD_READ);

  // Pipeline timing seen from the pins:
  //   edge 0 samples the controls of a cycle and registers
  //   the decoded write, read and mask,
  //   edge 1 drives the read word and its enable onto the pins.
  // A write registered at edge 0 lands in the array at edge 1, so a read
  // that directly follows a write sees the fresh word at edge 2.
  // Trade-off: one extra register stage in exchange for a clean
  // clock-to-pin path with no decode logic behind the pins.

  // Next state of the output stage; sleep outranks select and direction
  always_comb
  begin
    case (state)
      SWSD_IDLE, SWSD_WRITE, SWSD_READ, SWSD_SLEEP:
      begin
        // Sleep parks the stage with the pins off
        if (sleep_request)
          next_state = SWSD_SLEEP;
        // A deselected cycle carries nothing over
        else if (desel_now)
          next_state = SWSD_IDLE;
        // Write cycles never drive the pins
        else if (write_now)
          next_state = SWSD_WRITE;
        // A read drives the pins one edge later
        else
          next_state = SWSD_READ;
      end
      // Unused codes cannot occur; recover to idle anyway
      default:
        next_state = SWSD_IDLE;
    endcase
  end

  // State register; inputs are taken as synchronous
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      state <= SWSD_IDLE;
    else
      state <= next_state;
  end

  // Registered read and write flags; a deselected or sleeping cycle is neither
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cycle_write <= 1'h0;
      cycle_read  <= 1'h0;
    end
    else
    begin
      cycle_write <= active_now && write_now;
      cycle_read  <= active_now && read_now;
    end
  end

  // Registered lane mask; zero unless the cycle is a live write
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      lane_write_mask <= MASK_RST[NUM_LANES-1:0];
    else if (active_now)
      lane_write_mask <= mask_now;
    else
      lane_write_mask <= '0;
  end

  // Write data rides along with the mask; the mask alone decides what lands.
  // Copying it every edge costs a little power but keeps the path simple.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      lane_write_data <= '0;
    else
      lane_write_data <= write_data;
  end

  // Output data: the word of the registered read, else all zeros.
  // The array is read at the new address, so nothing of the prior write
  // leaks onto the bus; zeros stand for the released pins.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      data_out <= '0;
    else if (show_read)
      data_out <= array_read_data;
    else
      data_out <= '0;
  end

  // Output enable: drops on the edge after a deselect is registered;
  // sleeping and writing cycles release the pins the same way
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      data_out_en <= 1'h0;
    else
      data_out_en <= show_read;
  end

  // Select status: the plain three-enable decode, registered
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      selected <= 1'h0;
    else
      selected <= sel_now;
  end

  // Sleep status; the array keeps its contents while asleep
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      asleep <= 1'h0;
    else
      asleep <= sleep_request;
  end

endmodule : swsd_decode

`default_nettype wire

// ### bench/swsd_array_model.sv
// Array model holding one word, written lane by lane
`timescale 1ns/1ps
`default_nettype none
module swsd_array_model
  import swsd_pkg::*;
(
  input  wire logic        core_clk,        // Clock
  input  wire logic        rstn,            // Reset
  input  wire logic [3:0]  lane_write_mask, // Lanes to store
  input  wire logic [31:0] lane_write_data, // Data in
  output logic [31:0]      array_read_data  // Word out
);
  // Unmasked lanes keep their bytes
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
      array_read_data <= 32'h0;
    else
      for (int i = 0; i < LANES; i++)
        if (lane_write_mask[i])
          array_read_data[8*i+:8] <= lane_write_data[8*i+:8];
endmodule : swsd_array_model
`default_nettype wire

// ### bench/swsd_decode_sva.sv
// Checker of the decode outputs
`timescale 1ns/1ps
`default_nettype none
module swsd_decode_sva (
  input wire logic       core_clk, rstn, global_write_n, byte_write_gate_n, select_c_n,
  input wire logic       combined_select_n, select_b_high, sleep_request, cycle_write,
  input wire logic       cycle_read, selected, asleep, data_out_en,
  input wire logic [3:0] lane_write_n, lane_write_mask
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire sel = !combined_select_n && select_b_high && !select_c_n; // Enables agree
  wire on  = sel && !sleep_request;                               // Live cycle
  AST_GW: assert property (on && !global_write_n
    |=> cycle_write && lane_write_mask == 4'hF) else $error("gw");
  AST_LANE: assert property (on && global_write_n && !byte_write_gate_n
    |=> lane_write_mask == ~$past(lane_write_n)) else $error("lane");
  AST_RD: assert property (on && global_write_n && (byte_write_gate_n || &lane_write_n)
    |=> cycle_read && lane_write_mask == 4'h0) else $error("rd");
  AST_SEL: assert property (on |=> selected) else $error("sel");
  AST_DESEL: assert property (!sel |=> !(selected || cycle_write || cycle_read))
    else $error("desel");
  AST_SLEEP: assert property (sleep_request |=> asleep && !cycle_write && !cycle_read)
    else $error("sleep");
  AST_OFF: assert property (!sel |-> ##2 !data_out_en) else $error("off");
  AST_ENA: assert property (cycle_read && on |=> data_out_en) else $error("ena");
  cover property (on && !global_write_n);
  cover property (cycle_read && on);
  cover property (sleep_request);
  cover property (cycle_write ##1 cycle_read);
endmodule : swsd_decode_sva
bind swsd_decode swsd_decode_sva i_sva (.core_clk, .rstn, .global_write_n, .byte_write_gate_n,
  .select_c_n, .combined_select_n, .select_b_high, .sleep_request, .cycle_write, .cycle_read,
  .selected, .asleep, .data_out_en, .lane_write_n, .lane_write_mask);
`default_nettype wire

// ### bench/swsd_decode_test.sv
// Bench of the decode block with its array model
`timescale 1ns/1ps
`default_nettype none
module swsd_decode_test;
  import swsd_pkg::*;
  logic        core_clk = 1'b0, rstn = 1'b0, sleep_request;    // Clock, reset, sleep
  swsd_ctrl_t  ctl;                                           // Control pins
  logic        cycle_write, cycle_read, selected, asleep, data_out_en;
  logic [3:0]  lane_write_mask;                               // Lanes written
  logic [31:0] write_data, array_read_data, lane_write_data, data_out;
  logic [2:0]  pat [3] = '{3'b110, 3'b000, 3'b011};           // One enable off each
  int          err_count = 0, comparisons = 0;                // Tallies
  always #20 core_clk = ~core_clk;
  swsd_decode i_dut (.core_clk, .rstn, .global_write_n(ctl.global_write_n),
    .byte_write_gate_n(ctl.byte_write_gate_n), .lane_write_n(ctl.lane_write_n),
    .combined_select_n(ctl.combined_select_n), .select_b_high(ctl.select_b_high),
    .select_c_n(ctl.select_c_n), .sleep_request, .write_data, .array_read_data, .cycle_write,
    .cycle_read, .lane_write_mask, .lane_write_data, .data_out, .data_out_en, .selected, .asleep);
  swsd_array_model i_mem (.core_clk, .rstn, .lane_write_mask, .lane_write_data, .array_read_data);
  // One cycle of pins, set 1 ns after the edge
  task automatic step(input swsd_ctrl_t c, input logic z, input logic [31:0] d);
    ctl = c;
    sleep_request = z;
    write_data = d;
    @(posedge core_clk);
    #1;
  endtask : step
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Read at once; the word shows two edges later
  task automatic rd(input logic [31:0] exp);
    step(9'h1FA, 1'b0, 32'h0);
    check({31'h0, cycle_read}, 32'h1);
    step(9'h1FA, 1'b0, 32'h0);
    check(data_out, exp);
    check({31'h0, data_out_en}, 32'h1);
  endtask : rd
  task automatic t_write;
    step(9'h0FA, 1'b0, 32'h11223344);
    check({27'h0, cycle_write, lane_write_mask}, 32'h1F);
    check(lane_write_data, 32'h11223344);
    rd(32'h11223344);
    step({2'b10, 4'hE, 3'b010}, 1'b0, 32'hAABBCCDD);
    check({27'h0, cycle_write, lane_write_mask}, 32'h11);
    rd(32'h112233DD);
    step({2'b10, 4'h5, 3'b010}, 1'b0, 32'h5566EEFF);
    check({27'h0, cycle_write, lane_write_mask}, 32'h1A);
    step({2'b10, 4'hF, 3'b010}, 1'b0, 32'h0);
    check({26'h0, cycle_read, cycle_write, lane_write_mask}, 32'h20);
    step({2'b11, 4'h0, 3'b010}, 1'b0, 32'h0);
    check({26'h0, cycle_read, cycle_write, lane_write_mask}, 32'h20);
    rd(32'h5522EEDD);
    $display("write done");
  endtask : t_write
  task automatic t_desel;
    foreach (pat[i])
    begin
      step({6'h0F, pat[i]}, 1'b0, 32'hFFFFFFFF);
      check({26'h0, cycle_write, cycle_read, lane_write_mask}, 32'h0);
      step({6'h0F, pat[i]}, 1'b0, 32'hFFFFFFFF);
      check({31'h0, selected}, 32'h0);
      check({31'h0, data_out_en}, 32'h0);
    end
    rd(32'h5522EEDD);
    check({31'h0, selected}, 32'h1);
    $display("deselect done");
  endtask : t_desel
  task automatic t_sleep;
    step(9'h0FA, 1'b1, 32'h0);
    check({31'h0, asleep}, 32'h1);
    check({26'h0, cycle_write, cycle_read, lane_write_mask}, 32'h0);
    rd(32'h5522EEDD);
    check({31'h0, asleep}, 32'h0);
    $display("sleep done");
  endtask : t_sleep
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (4) step(9'h1FA, 1'b0, 32'h0);
    rstn = 1'b1;
    t_write;
    t_desel;
    t_sleep;
    report_and_stop;
  end
endmodule : swsd_decode_test
`default_nettype wire
